// ### logic/temp_adc_pkg.sv
// Constants, field positions and types for the temperature converter control block
package temp_adc_pkg;
	// Register addresses
	localparam logic [14:0] ADDR_CTRL = 15'h0030;
	localparam logic [14:0] ADDR_RESULT = 15'h0031;

	// Control register field positions
	localparam int unsigned CTRL_DONE_BIT = 0;
	localparam int unsigned CTRL_TRIG_BIT = 4;
	localparam int unsigned CTRL_CLK_EN_BIT = 5;
	localparam int unsigned CTRL_ADC_EN_BIT = 6;
	localparam int unsigned CTRL_RATE_BIT = 7;

	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] RESULT_RESET = 8'h00;

	// Serial frame layout: read/write flag, 15-bit address, 8 data bits
	localparam logic [4:0] SPI_INSTR_BITS = 5'h10;
	localparam logic [4:0] SPI_FRAME_BITS = 5'h18;
	localparam int unsigned SPI_RW_BIT = 15;

	// Converter clock rates and the derived divider periods
	localparam int unsigned CLK_SYS_HZ = 200_000_000;
	localparam int unsigned CONV_CLK_FAST_HZ = 2_000_000;
	localparam int unsigned CONV_CLK_SLOW_HZ = 250_000;
	localparam logic [9:0] CONV_DIV_FAST = 10'(CLK_SYS_HZ / CONV_CLK_FAST_HZ);
	localparam logic [9:0] CONV_DIV_SLOW = 10'(CLK_SYS_HZ / CONV_CLK_SLOW_HZ);
	localparam int unsigned RESULT_BITS = 8;

	typedef enum logic [3:0] {
		SAR_IDLE = 4'b0001,
		SAR_SAMPLE = 4'b0010,
		SAR_BITS = 4'b0100,
		SAR_FINISH = 4'b1000
	} sar_state_t;
endpackage

// ### logic/conv_if.sv
// Link between the register logic and the converter sequencer
`timescale 1ns/1ps
interface conv_if;
	logic start;
	logic clk_en;
	logic adc_en;
	logic rate_sel;
	logic done;
	logic busy;
	logic [7:0] result;

	modport ctrl (output start, output clk_en, output adc_en, output rate_sel,
		input done, input busy, input result);
	modport conv (input start, input clk_en, input adc_en, input rate_sel,
		output done, output busy, output result);
endinterface

// ### logic/sar_converter.sv
// Converter clock divider and 8-bit successive approximation sequencer
`timescale 1ns/1ps
module sar_converter (
	input wire logic clk_sys_in, // System clock
	input wire logic arst_n_in, // Asynchronous reset, active low
	conv_if.conv link, // Control and result link
	input wire logic cmp_in, // Analog comparator: sensor at or above trial code
	output logic [7:0] dac_code_out, // Trial code to the analog DAC
	output logic conv_clk_out, // Gated converter clock
	output logic sample_out // Sensor sample phase
);
	temp_adc_pkg::sar_state_t state_r;
	temp_adc_pkg::sar_state_t state_nxt;
	logic [9:0] div_cnt_r;
	logic conv_clk_r;
	logic cmp_meta_r;
	logic cmp_sync_r;
	logic [7:0] code_r;
	logic [2:0] bit_idx_r;
	logic [7:0] result_r;
	logic done_r;

	wire [9:0] div_period = link.rate_sel ? temp_adc_pkg::CONV_DIV_SLOW
		: temp_adc_pkg::CONV_DIV_FAST;
	wire div_wrap = (div_cnt_r == div_period - 10'h001);
	wire tick = link.clk_en && div_wrap;
	wire step = tick && link.adc_en;
	wire [7:0] bit_mask = 8'h01 << bit_idx_r;
	wire [7:0] kept_code = cmp_sync_r ? code_r : (code_r & ~bit_mask);
	wire [7:0] next_mask = bit_mask >> 1;

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			temp_adc_pkg::SAR_IDLE: if (link.start) state_nxt = temp_adc_pkg::SAR_SAMPLE;
			temp_adc_pkg::SAR_SAMPLE: if (step) state_nxt = temp_adc_pkg::SAR_BITS;
			temp_adc_pkg::SAR_BITS: if (step && bit_idx_r == 3'h0) state_nxt = temp_adc_pkg::SAR_FINISH;
			temp_adc_pkg::SAR_FINISH: state_nxt = temp_adc_pkg::SAR_IDLE;
			default: state_nxt = temp_adc_pkg::SAR_IDLE;
		endcase
		if (link.start)
			state_nxt = temp_adc_pkg::SAR_SAMPLE;
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			div_cnt_r <= 10'h000;
			conv_clk_r <= 1'b0;
			cmp_meta_r <= 1'b0;
			cmp_sync_r <= 1'b0;
		end
		else
		begin
			div_cnt_r <= (!link.clk_en || div_wrap) ? 10'h000 : div_cnt_r + 10'h001;
			conv_clk_r <= link.clk_en && (div_cnt_r < (div_period >> 1));
			cmp_meta_r <= cmp_in;
			cmp_sync_r <= cmp_meta_r;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_r <= temp_adc_pkg::SAR_IDLE;
			code_r <= 8'h00;
			bit_idx_r <= 3'h0;
			result_r <= temp_adc_pkg::RESULT_RESET;
			done_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			done_r <= (state_r == temp_adc_pkg::SAR_FINISH) && !link.start;
			if (link.start || (state_r == temp_adc_pkg::SAR_SAMPLE && step))
			begin
				code_r <= 8'h80;
				bit_idx_r <= 3'h7;
			end
			else if (state_r == temp_adc_pkg::SAR_BITS && step)
			begin
				code_r <= kept_code | next_mask;
				bit_idx_r <= bit_idx_r - 3'h1;
				if (bit_idx_r == 3'h0)
					result_r <= kept_code;
			end
		end
	end

	assign link.done = done_r;
	assign link.busy = (state_r != temp_adc_pkg::SAR_IDLE);
	assign link.result = result_r;
	assign dac_code_out = code_r;
	assign conv_clk_out = conv_clk_r;
	assign sample_out = (state_r == temp_adc_pkg::SAR_SAMPLE);
endmodule

// ### logic/temperature_adc_control.sv
// Serial-port register file and control for the on-chip temperature converter
`timescale 1ns/1ps
module temperature_adc_control (
	input wire logic clk_sys_in, // System clock, 200 MHz
	input wire logic arst_n_in, // Asynchronous reset, active low
	input wire logic spi_cs_n_in, // Serial chip select, active low
	input wire logic spi_sclk_in, // Serial clock from host
	input wire logic spi_sdio_in, // Serial data pin, input side
	output logic spi_sdio_out, // Serial data pin, output side
	output logic spi_sdio_oe_n_out, // Serial data pin drive enable, active low
	input wire logic temp_cmp_in, // Analog comparator result
	output logic [7:0] temp_dac_code_out, // Trial code to the analog DAC
	output logic conv_clk_out, // Gated converter clock
	output logic conv_sample_out // Sensor sample phase
);
	conv_if link ();

	// Pin synchronisers and edge history
	logic cs_meta_r;
	logic cs_sync_r;
	logic cs_prev_r;
	logic sclk_meta_r;
	logic sclk_sync_r;
	logic sclk_prev_r;
	logic sdio_meta_r;
	logic sdio_sync_r;

	// Serial frame state
	logic [4:0] bit_cnt_r;
	logic [4:0] bit_cnt_nxt;
	logic [23:0] shift_r;
	logic [23:0] shift_nxt;
	logic [7:0] rd_shift_r;
	logic [7:0] rd_shift_nxt;
	logic sdo_en_r;

	// Control register fields
	logic trig_r;
	logic clk_en_r;
	logic adc_en_r;
	logic rate_r;
	logic done_r;
	logic start_r;

	wire sclk_rise = sclk_sync_r && !sclk_prev_r;
	wire sclk_fall = !sclk_sync_r && sclk_prev_r;
	wire cs_active = !cs_sync_r;
	wire cs_rise = cs_sync_r && !cs_prev_r;
	wire frame_bit = cs_active && sclk_rise && (bit_cnt_r != temp_adc_pkg::SPI_FRAME_BITS);
	wire instr_done = frame_bit && (bit_cnt_r == temp_adc_pkg::SPI_INSTR_BITS - 5'h01);

	// The instruction sits in the low 16 bits once it has been shifted in
	wire [23:0] instr_view = shift_nxt;
	wire rd_req = instr_view[temp_adc_pkg::SPI_RW_BIT];
	wire [14:0] rd_addr = instr_view[14:0];

	// A complete write frame leaves the instruction above the data byte
	wire wr_frame = (bit_cnt_r == temp_adc_pkg::SPI_FRAME_BITS);
	wire wr_req = !shift_r[temp_adc_pkg::SPI_RW_BIT + 8];
	wire [14:0] wr_addr = shift_r[22:8];
	wire [7:0] wr_data = shift_r[7:0];
	wire commit = cs_rise && wr_frame && wr_req;
	wire ctrl_wr = commit && (wr_addr == temp_adc_pkg::ADDR_CTRL);

	// Register read-back
	wire [7:0] ctrl_view;
	wire [7:0] rd_data;
	wire rd_ctrl = (rd_addr == temp_adc_pkg::ADDR_CTRL);
	wire rd_result = (rd_addr == temp_adc_pkg::ADDR_RESULT);

	assign ctrl_view = {rate_r, adc_en_r, clk_en_r, trig_r, 3'b000, done_r};
	assign rd_data = rd_ctrl ? ctrl_view
		: rd_result ? link.result
		: 8'h00;

	// Frame shifting: sample on the host's rising edge, shift out on falling
	always_comb
	begin
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt = shift_r;
		rd_shift_nxt = rd_shift_r;
		if (!cs_active)
		begin
			bit_cnt_nxt = 5'h00;
		end
		else if (frame_bit)
		begin
			bit_cnt_nxt = bit_cnt_r + 5'h01;
			shift_nxt = {shift_r[22:0], sdio_sync_r};
		end
		if (instr_done)
			rd_shift_nxt = rd_data;
		else if (cs_active && sclk_fall && sdo_en_r && bit_cnt_r > temp_adc_pkg::SPI_INSTR_BITS)
			rd_shift_nxt = {rd_shift_r[6:0], 1'b0};
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			cs_meta_r <= 1'b1;
			cs_sync_r <= 1'b1;
			cs_prev_r <= 1'b1;
			sclk_meta_r <= 1'b0;
			sclk_sync_r <= 1'b0;
			sclk_prev_r <= 1'b0;
			sdio_meta_r <= 1'b0;
			sdio_sync_r <= 1'b0;
		end
		else
		begin
			cs_meta_r <= spi_cs_n_in;
			cs_sync_r <= cs_meta_r;
			cs_prev_r <= cs_sync_r;
			sclk_meta_r <= spi_sclk_in;
			sclk_sync_r <= sclk_meta_r;
			sclk_prev_r <= sclk_sync_r;
			sdio_meta_r <= spi_sdio_in;
			sdio_sync_r <= sdio_meta_r;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			bit_cnt_r <= 5'h00;
			shift_r <= 24'h00_0000;
			rd_shift_r <= 8'h00;
			sdo_en_r <= 1'b0;
		end
		else
		begin
			bit_cnt_r <= bit_cnt_nxt;
			shift_r <= shift_nxt;
			rd_shift_r <= rd_shift_nxt;
			if (!cs_active)
				sdo_en_r <= 1'b0;
			else if (instr_done)
				sdo_en_r <= rd_req;
		end
	end

	// Control register; write takes effect only when the frame closes
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			trig_r <= temp_adc_pkg::CTRL_RESET[temp_adc_pkg::CTRL_TRIG_BIT];
			clk_en_r <= temp_adc_pkg::CTRL_RESET[temp_adc_pkg::CTRL_CLK_EN_BIT];
			adc_en_r <= temp_adc_pkg::CTRL_RESET[temp_adc_pkg::CTRL_ADC_EN_BIT];
			rate_r <= temp_adc_pkg::CTRL_RESET[temp_adc_pkg::CTRL_RATE_BIT];
			start_r <= 1'b0;
		end
		else
		begin
			start_r <= ctrl_wr && wr_data[temp_adc_pkg::CTRL_TRIG_BIT];
			if (ctrl_wr)
			begin
				trig_r <= wr_data[temp_adc_pkg::CTRL_TRIG_BIT];
				clk_en_r <= wr_data[temp_adc_pkg::CTRL_CLK_EN_BIT];
				adc_en_r <= wr_data[temp_adc_pkg::CTRL_ADC_EN_BIT];
				rate_r <= wr_data[temp_adc_pkg::CTRL_RATE_BIT];
			end
		end
	end

	// Done flag: a finishing conversion wins over a clearing trigger
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			done_r <= temp_adc_pkg::CTRL_RESET[temp_adc_pkg::CTRL_DONE_BIT];
		else if (link.done)
			done_r <= 1'b1;
		else if (start_r)
			done_r <= 1'b0;
	end

	assign link.start = start_r;
	assign link.clk_en = clk_en_r;
	assign link.adc_en = adc_en_r;
	assign link.rate_sel = rate_r;

	sar_converter u_conv (
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.link(link.conv),
		.cmp_in(temp_cmp_in),
		.dac_code_out(temp_dac_code_out),
		.conv_clk_out(conv_clk_out),
		.sample_out(conv_sample_out)
	);

	// Read data is driven only in the data phase of a read frame
	assign spi_sdio_out = rd_shift_r[7];
	assign spi_sdio_oe_n_out = !(sdo_en_r && cs_active);
endmodule

// ### bench/temp_adc_props.sv
// Port-level assertions for the temperature converter control block
`timescale 1ns/1ps
module temp_adc_props (
	input wire logic clk_sys_in, // System clock
	input wire logic arst_n_in, // Reset, active low
	input wire logic spi_cs_n_in, // Chip select, active low
	input wire logic spi_sclk_in, // Serial clock
	input wire logic spi_sdio_in, // Serial data in
	input wire logic spi_sdio_out, // Serial data out
	input wire logic spi_sdio_oe_n_out, // Drive enable, active low
	input wire logic [7:0] temp_dac_code_out, // Trial code
	input wire logic conv_clk_out, // Converter clock
	input wire logic conv_sample_out // Sample phase
);
	logic sclk_d_r;
	logic rd_r;
	logic [4:0] rises_r;
	logic [1:0] cs_hi_r;
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!arst_n_in);
	// Raw rise count per frame and the frame's read flag
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sclk_d_r <= 1'b0;
			rises_r <= 5'h0;
			rd_r <= 1'b0;
			cs_hi_r <= 2'h0;
		end
		else
		begin
			sclk_d_r <= spi_sclk_in;
			if (!spi_cs_n_in)
				cs_hi_r <= 2'h0;
			else if (cs_hi_r != 2'h3)
				cs_hi_r <= cs_hi_r + 2'h1;
			// Keep the count until the synchronised chip select has closed the drive
			if (spi_cs_n_in)
			begin
				if (cs_hi_r == 2'h3)
					rises_r <= 5'h0;
			end
			else if (spi_sclk_in && !sclk_d_r && rises_r != 5'h1F)
			begin
				rises_r <= rises_r + 5'h1;
				if (rises_r == 5'h0)
					rd_r <= spi_sdio_in;
			end
		end
	end
	sequence s_sdo_still;
		$stable(spi_sdio_out) [*4];
	endsequence
	sequence s_clk_hi;
		conv_clk_out [*8];
	endsequence
	sequence s_clk_lo;
		!conv_clk_out [*8];
	endsequence
	property p_oe_idle;
		spi_cs_n_in [*6] |-> spi_sdio_oe_n_out;
	endproperty
	property p_oe_start;
		$fell(spi_sdio_oe_n_out) |-> spi_sclk_in && !spi_cs_n_in;
	endproperty
	property p_oe_read;
		!spi_sdio_oe_n_out |-> rd_r && rises_r >= 5'h10;
	endproperty
	property p_sdo_hold;
		!spi_sdio_oe_n_out && $rose(spi_sclk_in) |=> s_sdo_still;
	endproperty
	property p_first_trial;
		$fell(conv_sample_out) |-> ##[0:2] temp_dac_code_out[7];
	endproperty
	property p_dac_steady;
		$changed(temp_dac_code_out) && !conv_sample_out && !$past(conv_sample_out)
			|=> $stable(temp_dac_code_out) [*8];
	endproperty
	property p_clk_hi;
		$rose(conv_clk_out) |=> s_clk_hi;
	endproperty
	property p_clk_lo;
		$fell(conv_clk_out) |=> s_clk_lo;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("drive on without frame");
	a_oe_start: assert property (p_oe_start) else $error("drive began off edge");
	a_oe_read: assert property (p_oe_read) else $error("drive outside read data");
	a_sdo_hold: assert property (p_sdo_hold) else $error("read bit moved");
	a_first_trial: assert property (p_first_trial) else $error("first trial not msb");
	a_dac_steady: assert property (p_dac_steady) else $error("trial code too fast");
	a_clk_hi: assert property (p_clk_hi) else $error("converter clock high short");
	a_clk_lo: assert property (p_clk_lo) else $error("converter clock low short");
endmodule

// ### bench/spi_host_model.sv
// Serial host that frames register reads and writes
`timescale 1ns/1ps
module spi_host_model (
	input wire logic clk_sys_in, // System clock
	input wire logic sdo_in, // Data line as seen by host
	output logic cs_n_out, // Chip select, active low
	output logic sclk_out, // Serial clock, still between frames
	output logic sdo_out // Host drive of data line
);
	initial
	begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		sdo_out = 1'b0;
	end
	function automatic real to_celsius(input logic [7:0] code);
		return 1.05 * code - 80.0;
	endfunction
	// MSB first; a short count leaves the frame incomplete
	task automatic xfer(input logic [23:0] frame, input int nbits, output logic [7:0] rd);
		rd = 8'h00;
		cs_n_out = 1'b0;
		for (int i = 0; i < nbits; i++)
		begin
			repeat (8) @(negedge clk_sys_in);
			if (frame[23] && i > 15)
			begin
				rd = {rd[6:0], sdo_in};
				sdo_out = ~sdo_out; // Released line wanders
			end
			else
				sdo_out = frame[23 - i];
			repeat (8) @(negedge clk_sys_in);
			sclk_out = 1'b1;
			repeat (8) @(negedge clk_sys_in);
			sclk_out = 1'b0;
		end
		repeat (8) @(negedge clk_sys_in);
		cs_n_out = 1'b1;
		repeat (8) @(negedge clk_sys_in);
	endtask
endmodule

// ### bench/tb_temperature_adc_control.sv
// Self-checking bench for the temperature converter control block
`timescale 1ns/1ps
module tb_temperature_adc_control;
	logic clk_sys_in;
	logic arst_n_in;
	logic spi_cs_n_in;
	logic spi_sclk_in;
	logic spi_sdio_in;
	logic spi_sdio_out;
	logic spi_sdio_oe_n_out;
	logic temp_cmp_in;
	logic [7:0] temp_dac_code_out;
	logic conv_clk_out;
	logic conv_sample_out;
	logic host_d;
	logic [7:0] target;
	logic [7:0] rd;
	int miscompares;
	int checked;
	int rises;
	time t0;
	time per;
	assign spi_sdio_in = spi_sdio_oe_n_out ? host_d : spi_sdio_out;
	temperature_adc_control temperature_adc_control_inst (.clk_sys_in, .arst_n_in,
		.spi_cs_n_in, .spi_sclk_in, .spi_sdio_in, .spi_sdio_out, .spi_sdio_oe_n_out,
		.temp_cmp_in, .temp_dac_code_out, .conv_clk_out, .conv_sample_out);
	spi_host_model spi_host_model_inst (.clk_sys_in, .sdo_in(spi_sdio_in),
		.cs_n_out(spi_cs_n_in), .sclk_out(spi_sclk_in), .sdo_out(host_d));
	// Comparator: sensor at or above the trial code
	always @(negedge clk_sys_in)
		temp_cmp_in <= temp_dac_code_out <= target;
	always @(posedge conv_clk_out)
	begin
		per = $time - t0;
		t0 = $time;
		rises++;
	end
	initial
	begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd_reg(input logic [14:0] a, output logic [7:0] d);
		spi_host_model_inst.xfer({1'b1, a, 8'h00}, 24, d);
	endtask
	task automatic wr_reg(input logic [14:0] a, input logic [7:0] d);
		logic [7:0] nc;
		spi_host_model_inst.xfer({1'b0, a, d}, 24, nc);
	endtask
	task automatic t_reset();
		rd_reg(temp_adc_pkg::ADDR_CTRL, rd);
		check(rd, 8'h00);
		wr_reg(temp_adc_pkg::ADDR_RESULT, 8'hFF);
		rd_reg(15'h0055, rd);
		check(rd, 8'h00);
		rd_reg(temp_adc_pkg::ADDR_RESULT, rd);
		check(rd, 8'h00);
	endtask
	task automatic t_gates();
		wr_reg(temp_adc_pkg::ADDR_CTRL, 8'h51);
		repeat (2000) @(negedge clk_sys_in);
		check(rises, 0);
		rd_reg(temp_adc_pkg::ADDR_CTRL, rd);
		check(rd, 8'h50);
		wr_reg(temp_adc_pkg::ADDR_CTRL, 8'h30);
		repeat (2000) @(negedge clk_sys_in);
		check(rises > 10, 1);
		check(per, 500);
		rd_reg(temp_adc_pkg::ADDR_CTRL, rd);
		check(rd, 8'h30);
	endtask
	task automatic t_short();
		spi_host_model_inst.xfer({1'b0, temp_adc_pkg::ADDR_CTRL, 8'h00}, 23, rd);
		rd_reg(temp_adc_pkg::ADDR_CTRL, rd);
		check(rd, 8'h30);
	endtask
	task automatic t_conv(input logic rate, input logic [7:0] code);
		logic [7:0] ctl;
		int n;
		ctl = {rate, 7'h70};
		target = code;
		wr_reg(temp_adc_pkg::ADDR_CTRL, ctl);
		rd_reg(temp_adc_pkg::ADDR_CTRL, rd);
		check(rd, ctl);
		n = 0;
		while (rd[0] !== 1'b1 && n < 100)
		begin
			rd_reg(temp_adc_pkg::ADDR_CTRL, rd);
			n++;
		end
		check(rd, ctl | 8'h01);
		rd_reg(temp_adc_pkg::ADDR_RESULT, rd);
		check(rd, code);
		check(int'(spi_host_model_inst.to_celsius(rd) * 100.0), 105 * rd - 8000);
		check(per, rate ? 4000 : 500);
	endtask
	task automatic summarize();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (80000) @(posedge clk_sys_in);
		miscompares++;
		summarize();
	end
	initial
	begin
		arst_n_in = 1'b0;
		target = 8'h00;
		miscompares = 0;
		checked = 0;
		rises = 0;
		t0 = 0;
		per = 0;
		repeat (10) @(negedge clk_sys_in);
		arst_n_in = 1'b1;
		repeat (4) @(negedge clk_sys_in);
		t_reset();
		t_gates();
		t_short();
		t_conv(1'b0, 8'hFF);
		t_conv(1'b0, 8'h00);
		t_conv(1'b1, 8'h5A);
		summarize();
	end
endmodule
bind temperature_adc_control temp_adc_props temp_adc_props_inst (.clk_sys_in, .arst_n_in,
	.spi_cs_n_in, .spi_sclk_in, .spi_sdio_in, .spi_sdio_out, .spi_sdio_oe_n_out,
	.temp_dac_code_out, .conv_clk_out, .conv_sample_out);
